/* bench/cssc_pin_model.sv */
// Shutdown pin driver standing in for the board switch
`default_nettype none
module cssc_pin_model (
  // Clock
  input  wire logic clk,
  // Pin
  output var  logic shutdown_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial shutdown_pin = 1'b0;
  // Hold each level well past the synchroniser so nothing is missed
  task automatic level(input logic v);
    @(posedge clk) shutdown_pin <= v;
    repeat (4) @(posedge clk);
    #1;
  endtask : level
  // Momentary press with a low gap long enough to be sampled
  task automatic press();
    level(1'b1);
    level(1'b0);
  endtask : press
endmodule : cssc_pin_model
`default_nettype wire

/* bench/cssc_testbench.sv */
// Self-checking bench for the clock select and shutdown controller
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import cssc_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [31:0] reg_wr_data = 32'h0000_0000, reg_rd_data;
  logic        reg_rd_valid, shutdown_pin, clk_src_sel, clk_rate_ok, dev_enabled, pm_osc_run;
  logic [2:0]  clk_rate_code;
  logic [4:0]  derived_clk_en;
  int          bad_count = 0, n_compared = 0, cycles = 0;
  cssc_ctrl u_cssc_ctrl (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid), .shutdown_pin(shutdown_pin), .clk_src_sel(clk_src_sel),
    .clk_rate_code(clk_rate_code), .clk_rate_ok(clk_rate_ok),
    .derived_clk_en(derived_clk_en), .dev_enabled(dev_enabled), .pm_osc_run(pm_osc_run));
  cssc_pin_model u_cssc_pin_model (.clk(clk), .shutdown_pin(shutdown_pin));
  // 25 MHz clock
  always #20 clk = ~clk;
  task automatic close_out();
    if (bad_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One write strobe, then let the enable state settle
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk) reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= 1'b1;
    @(posedge clk) reg_wr_en <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : wr
  // One read strobe; data and valid are due exactly one cycle later
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
    @(posedge clk) reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk) reg_rd_en <= 1'b0;
    #1;
    chk(32'(reg_rd_valid), 32'h1);
    chk(reg_rd_data, exp);
    @(posedge clk) #1;
    chk(32'(reg_rd_valid), 32'h0);
  endtask : rd_chk
  // Reset in mid-run returns to hardware mode with defaults
  task automatic t_rerst();
    wr(CFG_ADDR, 32'h0000_0803);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(32'(dev_enabled), 32'h0);
    chk(32'(clk_src_sel), 32'h0);
    rd_chk(CFG_ADDR, 32'h0000_0000);
  endtask : t_rerst
  task automatic t_reset();
    chk(32'(dev_enabled), 32'h0);
    chk(32'(pm_osc_run), 32'h1);
    rd_chk(CFG_ADDR, 32'h0000_0000);
    rd_chk(16'h0520, 32'h0000_0000);
  endtask : t_reset
  task automatic t_soft();
    wr(CFG_ADDR, 32'h0000_0803);
    chk(32'(clk_src_sel), 32'h1);
    chk(32'(dev_enabled), 32'h1);
    u_cssc_pin_model.level(1'b0);
    chk(32'(dev_enabled), 32'h1);
    wr(CFG_ADDR, 32'h0000_0802);
    chk(32'(dev_enabled), 32'h0);
    rd_chk(CFG_ADDR, 32'h0000_0802);
    wr(CFG_ADDR, 32'h0000_ffff);
    rd_chk(CFG_ADDR, 32'h0000_5f07);
  endtask : t_soft
  // Every rate code, the three unsupported ones gating all clocks off
  task automatic t_rates();
    for (int c = 0; c < 8; c++) begin
      wr(CFG_ADDR, (32'(c) << 8) | 32'h0000_0003);
      chk(32'(clk_rate_code), 32'(c));
      chk(32'(clk_rate_ok), 32'(c < 5));
      chk(32'(derived_clk_en), (c < 5) ? 32'h1f : 32'h0);
      chk(32'(clk_src_sel), 32'h0);
    end
  endtask : t_rates
  // Oscillator stops only with both bits set
  task automatic t_osc();
    for (int i = 0; i < 4; i++) begin
      wr(CFG_ADDR, (32'(i & 1) << 12) | (32'(i >> 1) << 14));
      chk(32'(pm_osc_run), 32'(i != 3));
    end
  endtask : t_osc
  task automatic t_hw();
    wr(CFG_ADDR, 32'h0000_0000);
    u_cssc_pin_model.level(1'b1);
    chk(32'(dev_enabled), 32'h1);
    u_cssc_pin_model.level(1'b0);
    chk(32'(dev_enabled), 32'h0);
    wr(CFG_ADDR, 32'h0000_0004);
    u_cssc_pin_model.press();
    chk(32'(dev_enabled), 32'h1);
    u_cssc_pin_model.level(1'b1);
    repeat (6) @(posedge clk);
    #1;
    chk(32'(dev_enabled), 32'h0);
  endtask : t_hw
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    t_reset();
    t_soft();
    t_rates();
    t_osc();
    t_hw();
    t_rerst();
    close_out();
  end
endmodule : testbench
`default_nettype wire

/* core/cssc_ctrl.sv */
// Clock source selection and hardware/software shutdown control
// Function
// R1 - The system must always supply an external clock; the device needs it.
// R2 - Converter, mixer, processor, serial port and modulator clocks come from the selected clock.
// R3 - Bit 11 of the configuration register picks master clock at 0, bit clock at 1.
// R4 - Bits 10:8 declare the source rate; five frequencies are supported.
// R5 - With both clocks present the host should select the slower one.
// R6 - After power-up the device runs in hardware shutdown mode.
// R7 - Mode bit 1 at 0 takes enable state from the shutdown pin.
// R8 - Level option: pin high enables, pin low disables, needs a stable level.
// R9 - Pulse option bit 2 set: each pin rising edge toggles enabled state.
// R10 - Mode bit 1 at 1 selects software mode; pin no longer controls state.
// R11 - In software mode enable bit 0 disables at 0 and enables at 1.
// R12 - Configuration contents are kept while disabled, in either mode.
// R13 - Bits 12 and 14 both set stop the power-management oscillator.
// R14 - Pin is synchronised and edges found from consecutive samples, one change per press.
`default_nettype none
module cssc_ctrl (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Register port from the control interface
  input  wire logic [cssc_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic                          reg_wr_en,
  input  wire logic [cssc_pkg::DATA_W-1:0]   reg_wr_data,
  input  wire logic                          reg_rd_en,
  output logic      [cssc_pkg::DATA_W-1:0]   reg_rd_data,
  output logic                               reg_rd_valid,
  // Shutdown pin, asynchronous to clk
  input  wire logic                          shutdown_pin,
  // Clock routing to the datapath
  output logic                               clk_src_sel,
  output logic      [cssc_pkg::RATE_W-1:0]   clk_rate_code,
  output logic                               clk_rate_ok,
  output logic      [cssc_pkg::NUM_CLKS-1:0] derived_clk_en,
  // Power state
  output logic                               dev_enabled,
  output logic                               pm_osc_run
);
  import cssc_pkg::*;

  logic [DATA_W-1:0]      cfg_reg;
  logic [SYNC_STAGES-1:0] pin_sync_reg;
  logic                   pin_prev_reg;
  logic                   pin_rise;
  logic                   dev_en_reg;
  logic                   dev_en_next;
  logic                   cfg_sel;
  logic                   hw_mode;

  // Decode of the one mapped register address
  function automatic logic is_cfg(input logic [ADDR_W-1:0] a);
    is_cfg = (a == CFG_ADDR);
  endfunction : is_cfg

  // Check a rate code against the supported set
  function automatic logic rate_supported(input logic [RATE_W-1:0] r);
    rate_supported = (r == RATE_1536K) || (r == RATE_3072K) || (r == RATE_6114K) ||
                     (r == RATE_12288K) || (r == RATE_24576K);
  endfunction : rate_supported

  assign cfg_sel = is_cfg(reg_addr);
  assign hw_mode = !cfg_reg[FORCE_BIT]; // R7 R10

  // Configuration register; disabling never touches it, only writes and reset do
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_reg <= CFG_RESET; // R6
    end else if (reg_wr_en && cfg_sel) begin
      cfg_reg <= reg_wr_data & CFG_WMASK; // R12
    end
  end

  // Registered read data; unmapped addresses read as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rd_data  <= '0;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rd_data <= cfg_sel ? cfg_reg : '0;
      end
    end
  end

  // Two-stage synchroniser on the pin; only the last stage is looked at
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_sync_reg <= '0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[SYNC_STAGES-2:0], shutdown_pin}; // R14
    end
  end

  // Previous synchronised sample, so one press yields one edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= pin_sync_reg[SYNC_STAGES-1];
    end
  end

  assign pin_rise = pin_sync_reg[SYNC_STAGES-1] && !pin_prev_reg; // R14

  // Enable state selection; pulse mode toggles from the present state,
  // so switching into pulse mode never causes a spurious jump
  always_comb begin
    if (!hw_mode) begin
      dev_en_next = cfg_reg[ENABLE_BIT]; // R10 R11
    end else if (cfg_reg[PULSE_BIT]) begin
      dev_en_next = dev_en_reg ^ pin_rise; // R9
    end else begin
      dev_en_next = pin_sync_reg[SYNC_STAGES-1]; // R8
    end
  end

  // Device enable state, disabled out of reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dev_en_reg <= 1'b0;
    end else begin
      dev_en_reg <= dev_en_next; // R7
    end
  end

  assign dev_enabled = dev_en_reg;

  // Clock routing; an unsupported rate code keeps all derived clocks off
  // rather than running the datapath at a wrong ratio
  assign clk_src_sel    = cfg_reg[SRC_BIT]; // R3
  assign clk_rate_code  = cfg_reg[RATE_LSB +: RATE_W]; // R4
  assign clk_rate_ok    = rate_supported(clk_rate_code); // R4
  assign derived_clk_en = {NUM_CLKS{dev_en_reg && clk_rate_ok}}; // R2 R1

  // Oscillator stops only with both bits set, guarding against a stray single write
  assign pm_osc_run = !(cfg_reg[OSC_SEL_BIT] && cfg_reg[OSC_STP_BIT]); // R13

  // Checks
  a_src_select: assert property (@(posedge clk) disable iff (rst)
    reg_wr_en && cfg_sel |=> clk_src_sel == $past(reg_wr_data[SRC_BIT]))
    else $error("clock source select does not follow written bit"); // R3
  a_rate_gate: assert property (@(posedge clk) disable iff (rst)
    !clk_rate_ok |-> derived_clk_en == '0)
    else $error("derived clocks run with unsupported rate"); // R4
  a_derived_clk: assert property (@(posedge clk) disable iff (rst)
    $rose(dev_enabled) && clk_rate_ok |-> &derived_clk_en)
    else $error("derived clocks not enabled with device"); // R2
  a_reset_hw_mode: assert property (@(posedge clk)
    $past(rst) && !rst |-> !cfg_reg[FORCE_BIT] && !dev_enabled)
    else $error("not in hardware mode after reset"); // R6
  a_level_follow: assert property (@(posedge clk) disable iff (rst)
    hw_mode && !cfg_reg[PULSE_BIT] && !reg_wr_en && $rose(pin_sync_reg[SYNC_STAGES-1])
    |=> dev_enabled)
    else $error("level mode did not enable on high pin"); // R8
  a_level_off: assert property (@(posedge clk) disable iff (rst)
    hw_mode && !cfg_reg[PULSE_BIT] && !pin_sync_reg[SYNC_STAGES-1] |=> !dev_enabled)
    else $error("level mode enabled with low pin"); // R7
  a_pulse_toggle: assert property (@(posedge clk) disable iff (rst)
    hw_mode && cfg_reg[PULSE_BIT] && pin_rise |=> dev_enabled != $past(dev_enabled))
    else $error("rising edge did not toggle state"); // R9
  a_pulse_hold: assert property (@(posedge clk) disable iff (rst)
    hw_mode && cfg_reg[PULSE_BIT] && !pin_rise |=> $stable(dev_enabled))
    else $error("pulse mode changed state without an edge"); // R9
  a_sw_ignore_pin: assert property (@(posedge clk) disable iff (rst)
    !hw_mode |=> dev_enabled == $past(cfg_reg[ENABLE_BIT]))
    else $error("software mode state not taken from enable bit"); // R10
  a_sw_enable: assert property (@(posedge clk) disable iff (rst)
    reg_wr_en && cfg_sel && reg_wr_data[FORCE_BIT] && reg_wr_data[ENABLE_BIT]
    ##1 !reg_wr_en |-> ##1 dev_enabled)
    else $error("software enable did not enable device in two cycles"); // R11
  a_cfg_retained: assert property (@(posedge clk) disable iff (rst)
    !dev_enabled && !reg_wr_en |=> $stable(cfg_reg))
    else $error("configuration changed while disabled"); // R12
  a_osc_stop: assert property (@(posedge clk) disable iff (rst)
    reg_wr_en && cfg_sel && reg_wr_data[OSC_SEL_BIT] && reg_wr_data[OSC_STP_BIT]
    |=> !pm_osc_run)
    else $error("oscillator still running after stop write"); // R13
  a_edge_once: assert property (@(posedge clk) disable iff (rst)
    pin_rise |=> !pin_rise)
    else $error("one edge detected twice"); // R14

  // Register port timing: valid one cycle after the strobe, data held between reads
  a_rd_valid_lag: assert property (@(posedge clk) disable iff (rst) // R12
    reg_rd_en |=> reg_rd_valid)
    else $error("read valid missing one cycle after strobe");
  a_rd_valid_drop: assert property (@(posedge clk) disable iff (rst) // R12
    !reg_rd_en |=> !reg_rd_valid)
    else $error("read valid high without a strobe");
  a_rd_data_cfg: assert property (@(posedge clk) disable iff (rst) // R12
    reg_rd_en && cfg_sel |=> reg_rd_data == $past(cfg_reg))
    else $error("read data differs from configuration");
  a_rd_data_unmapped: assert property (@(posedge clk) disable iff (rst) // R12
    reg_rd_en && !cfg_sel |=> reg_rd_data == '0)
    else $error("unmapped read returned nonzero data");
  a_rd_data_hold: assert property (@(posedge clk) disable iff (rst) // R12
    !reg_rd_en |=> $stable(reg_rd_data))
    else $error("read data changed without a read");

  // Writes land only at the mapped address, masked to the implemented bits
  a_wr_unmapped: assert property (@(posedge clk) disable iff (rst) // R12
    reg_wr_en && !cfg_sel |=> $stable(cfg_reg))
    else $error("unmapped write changed configuration");
  a_wr_lands: assert property (@(posedge clk) disable iff (rst) // R12
    reg_wr_en && cfg_sel |=> cfg_reg == ($past(reg_wr_data) & CFG_WMASK))
    else $error("write did not land in configuration");
  a_no_write_hold: assert property (@(posedge clk) disable iff (rst) // R12
    !reg_wr_en |=> $stable(cfg_reg))
    else $error("configuration changed without a write");
  a_retain_disable: assert property (@(posedge clk) disable iff (rst) // R12
    $fell(dev_enabled) && !$past(reg_wr_en) |-> $stable(cfg_reg))
    else $error("disabling the device altered configuration");

  // Clock source and rate follow the register and nothing else
  a_src_mclk: assert property (@(posedge clk) disable iff (rst) // R3
    reg_wr_en && cfg_sel && !reg_wr_data[SRC_BIT] |=> clk_src_sel == SRC_MCLK)
    else $error("master clock not selected after write");
  a_src_sclk: assert property (@(posedge clk) disable iff (rst) // R3
    reg_wr_en && cfg_sel && reg_wr_data[SRC_BIT] |=> clk_src_sel == SRC_SCLK)
    else $error("bit clock not selected after write");
  a_src_stable: assert property (@(posedge clk) disable iff (rst) // R3
    !reg_wr_en |=> $stable(clk_src_sel))
    else $error("clock source changed without a write");
  a_rate_follow: assert property (@(posedge clk) disable iff (rst) // R4
    reg_wr_en && cfg_sel |=> clk_rate_code == $past(reg_wr_data[RATE_LSB +: RATE_W]))
    else $error("rate code does not follow written field");
  a_rate_stable: assert property (@(posedge clk) disable iff (rst) // R4
    !reg_wr_en |=> $stable(clk_rate_code))
    else $error("rate code changed without a write");
  a_rate_valid: assert property (@(posedge clk) disable iff (rst) // R4
    (clk_rate_code <= RATE_24576K) |-> clk_rate_ok)
    else $error("supported rate code flagged as bad");
  a_rate_invalid: assert property (@(posedge clk) disable iff (rst) // R4
    (clk_rate_code > RATE_24576K) |-> !clk_rate_ok)
    else $error("unsupported rate code flagged as good");

  // Derived clocks run only while the device is enabled
  a_clk_off_disabled: assert property (@(posedge clk) disable iff (rst) // R2
    !dev_enabled |-> derived_clk_en == '0)
    else $error("derived clocks run while disabled");
  a_clk_on: assert property (@(posedge clk) disable iff (rst) // R2
    dev_enabled && clk_rate_ok |-> &derived_clk_en)
    else $error("derived clock missing while enabled");

  // Oscillator keeps running unless both stop bits are set
  a_osc_run_sel: assert property (@(posedge clk) disable iff (rst) // R13
    !cfg_reg[OSC_SEL_BIT] |-> pm_osc_run)
    else $error("oscillator stopped without select bit");
  a_osc_run_stp: assert property (@(posedge clk) disable iff (rst) // R13
    !cfg_reg[OSC_STP_BIT] |-> pm_osc_run)
    else $error("oscillator stopped without stop bit");
  a_osc_both: assert property (@(posedge clk) disable iff (rst) // R13
    cfg_reg[OSC_SEL_BIT] && cfg_reg[OSC_STP_BIT] |-> !pm_osc_run)
    else $error("oscillator runs with both stop bits set");
  a_osc_stable: assert property (@(posedge clk) disable iff (rst) // R13
    !reg_wr_en |=> $stable(pm_osc_run))
    else $error("oscillator state changed without a write");

  // Shutdown state per mode
  a_level_on_hold: assert property (@(posedge clk) disable iff (rst) // R8
    hw_mode && !cfg_reg[PULSE_BIT] && pin_sync_reg[SYNC_STAGES-1] |=> dev_enabled)
    else $error("level mode disabled with high pin");
  a_hw_pin_source: assert property (@(posedge clk) disable iff (rst) // R7
    hw_mode && !cfg_reg[PULSE_BIT] |=> dev_enabled == $past(pin_sync_reg[SYNC_STAGES-1]))
    else $error("hardware level mode state not taken from pin");
  a_pulse_held_high: assert property (@(posedge clk) disable iff (rst) // R9
    hw_mode && cfg_reg[PULSE_BIT] && pin_sync_reg[SYNC_STAGES-1] && pin_prev_reg
    |=> $stable(dev_enabled))
    else $error("held high pin toggled state");
  a_sw_pin_blind: assert property (@(posedge clk) disable iff (rst) // R10
    !hw_mode && $stable(cfg_reg) |=> $stable(dev_enabled))
    else $error("software mode state moved without a write");
  a_sw_disable: assert property (@(posedge clk) disable iff (rst) // R11
    reg_wr_en && cfg_sel && reg_wr_data[FORCE_BIT] && !reg_wr_data[ENABLE_BIT]
    ##1 !reg_wr_en |-> ##1 !dev_enabled)
    else $error("software disable did not disable device in two cycles");

  // Synchroniser and edge detector stage by stage
  a_sync_lag: assert property (@(posedge clk) disable iff (rst) // R14
    pin_sync_reg[SYNC_STAGES-1] == $past(pin_sync_reg[0]))
    else $error("synchroniser stage skipped");
  a_prev_lag: assert property (@(posedge clk) disable iff (rst) // R14
    pin_prev_reg == $past(pin_sync_reg[SYNC_STAGES-1]))
    else $error("previous sample not one cycle behind");
  a_edge_seen: assert property (@(posedge clk) disable iff (rst) // R14
    $rose(pin_sync_reg[SYNC_STAGES-1]) |-> pin_rise)
    else $error("synchronised rise not detected");

  // State right after reset release
  a_reset_clk_off: assert property (@(posedge clk) // R6
    $past(rst) && !rst |-> derived_clk_en == '0 && pm_osc_run)
    else $error("clocks or oscillator wrong after reset");
  a_reset_rd_idle: assert property (@(posedge clk) // R6
    $past(rst) && !rst |-> !reg_rd_valid && reg_rd_data == '0)
    else $error("read port not idle after reset");
  a_reset_src: assert property (@(posedge clk) // R6
    $past(rst) && !rst |-> clk_src_sel == SRC_MCLK && clk_rate_code == RATE_1536K)
    else $error("clock selection not at default after reset");

  c_pulse_toggle: cover property (@(posedge clk) disable iff (rst)
    hw_mode && cfg_reg[PULSE_BIT] && pin_rise ##1 dev_enabled);
  c_level_enable: cover property (@(posedge clk) disable iff (rst)
    hw_mode && !cfg_reg[PULSE_BIT] && $rose(dev_enabled));
  c_sw_enable: cover property (@(posedge clk) disable iff (rst)
    !hw_mode && $rose(dev_enabled));
  c_osc_stop: cover property (@(posedge clk) disable iff (rst)
    !dev_enabled && !pm_osc_run);
  c_rate_invalid: cover property (@(posedge clk) disable iff (rst)
    hw_mode && !clk_rate_ok);
endmodule : cssc_ctrl
`default_nettype wire

/* core/cssc_pkg.sv */
// Constants for the clock select and shutdown controller
`default_nettype none
package cssc_pkg;
  // Register port geometry
  localparam int unsigned ADDR_W      = 16;
  localparam int unsigned DATA_W      = 32;
  // Enable and clock configuration register
  localparam logic [15:0] CFG_ADDR    = 16'h0521;
  localparam logic [31:0] CFG_RESET   = 32'h0000_0000; // Hardware shutdown mode, device and derived clocks off, oscillator running
  localparam logic [31:0] CFG_WMASK   = 32'h0000_5f07; // Implemented bits
  // Field positions
  localparam int unsigned ENABLE_BIT  = 0;
  localparam int unsigned FORCE_BIT   = 1;
  localparam int unsigned PULSE_BIT   = 2;
  localparam int unsigned RATE_LSB    = 8;
  localparam int unsigned RATE_W      = 3;
  localparam int unsigned SRC_BIT     = 11;
  localparam int unsigned OSC_SEL_BIT = 12;
  localparam int unsigned OSC_STP_BIT = 14;
  // Number of derived clock consumers: converter, mixer, processor, serial port, modulator
  localparam int unsigned NUM_CLKS    = 5;
  // Rate codes for the five supported source frequencies
  localparam logic [2:0]  RATE_1536K  = 3'h0;
  localparam logic [2:0]  RATE_3072K  = 3'h1;
  localparam logic [2:0]  RATE_6114K  = 3'h2;
  localparam logic [2:0]  RATE_12288K = 3'h3;
  localparam logic [2:0]  RATE_24576K = 3'h4;
  // Source select encodings
  localparam logic        SRC_MCLK    = 1'b0;
  localparam logic        SRC_SCLK    = 1'b1;
  // Shutdown pin synchroniser depth
  localparam int unsigned SYNC_STAGES = 2;
endpackage : cssc_pkg
`default_nettype wire
